// ### include/point_table_defines.vh
// Offsets, field positions, reset values and timing counts of the point table sequencer
`ifndef POINT_TABLE_DEFINES_VH
`define POINT_TABLE_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define REG_CTRL          8'h00
`define REG_CONFIG        8'h04
`define REG_TARGET_TABLE  8'h08
`define REG_GLOBAL_DECEL  8'h0C
`define REG_TBL_INDEX     8'h10
`define REG_TBL_POSITION  8'h14
`define REG_TBL_SPEED     8'h18
`define REG_TBL_DECEL     8'h1C
`define REG_TBL_DWELL     8'h20
`define REG_TBL_AUX       8'h24
`define REG_STATUS        8'h28
`define REG_ACTIVE_CODE   8'h2C
`define REG_CMD_POSITION  8'h30
`define REG_CMD_SPEED     8'h34
`define REG_CMD_DECEL     8'h38
`define REG_MAX_SPEED     8'h3C

// ==========================================================================
// Field positions
`define CTRL_NEW_SETPOINT     4
`define CTRL_ERR_CLEAR        8
`define CFG_TRAVEL_DIR        0
`define CFG_RATE_UNIT         1
`define CFG_LINEAR_MODE       2
`define CFG_POS_UNIT_LO       4
`define CFG_POS_UNIT_HI       5
`define AUX_CODE_HI           3
`define AUX_MCODE_LO          8
`define AUX_MCODE_HI          15

// ==========================================================================
// Codes and limits
`define UNIT_DEGREE           2'h2
`define DEG_LIMIT             32'h00057E40
`define DECEL_MS_MAX          32'h00004E20
`define DWELL_MS_MAX          32'h00004E20
`define LAST_TABLE            8'hFF
`define FIRST_TABLE           8'h01

// ==========================================================================
// Reset values
`define RST_GLOBAL_DECEL      32'h00000000
`define RST_MAX_SPEED         32'h0000EA60

// ==========================================================================
// Timing: one millisecond at 250 MHz
`define CLK_MHZ               250
`define MS_CYCLES             (`CLK_MHZ * 1000)

`endif

// ### rtl/table_memory.v
// Point table storage with a registered read port
`timescale 1ns/10ps
module table_memory #(
  parameter WIDTH = 32,
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  // Clock
  input  wire             sys_clk_i,
  // Write port
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  // Read port
  input  wire [AW-1:0]    rd_addr_i,
  output reg  [WIDTH-1:0] rd_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// ### rtl/point_table_sequencer.v
// Point table positioning sequencer with AXI4-Lite register access
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "point_table_defines.vh"
module point_table_sequencer #(
  parameter MS_COUNT = `MS_CYCLES
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Motion generator handshake
  input  wire        motion_done_i,
  input  wire        smooth_zero_i,
  input  wire        motor_moving_i,
  output reg         cmd_start_o,
  output reg  [31:0] cmd_position_o,
  output reg         cmd_relative_o,
  output reg  [31:0] cmd_speed_o,
  output reg  [31:0] cmd_decel_o,
  output reg         cmd_decel_is_rate_o,
  output reg         cmd_speed_mm_o,
  output reg         busy_o,
  output reg         table_error_o
);

  // ========================================================================
  // State codes
  localparam ST_IDLE  = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_CHECK = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_DWELL = 3'h4;
  localparam ST_TURN  = 3'h5;

  function aux_valid;
    input [3:0] code;
    begin
      aux_valid = (code <= 4'h3) || ((code >= 4'h8) && (code <= 4'hB));
    end
  endfunction

  function continues;
    input [3:0] code;
    begin
      continues = (code[1:0] == 2'h1) || (code[1:0] == 2'h3) || code[3];
    end
  endfunction

  // ========================================================================
  // Registers
  reg  [31:0] config_ff;
  reg  [7:0]  target_table_ff;
  reg  [31:0] global_decel_time_param_ff;
  reg  [31:0] max_speed_ff;
  reg  [7:0]  tbl_index_ff;
  reg  [15:0] active_code_ff;
  reg  [2:0]  state_ff;
  reg  [7:0]  cur_table_ff;
  reg  [7:0]  start_table_ff;
  reg  [31:0] ms_cnt_ff;
  reg  [31:0] dwell_cnt_ff;
  reg  [31:0] pos_ff;
  reg  [31:0] spd_ff;
  reg  [31:0] dec_ff;
  reg  [31:0] aux_ff;
  reg         prev_neg_ff;
  reg         have_prev_ff;
  reg         aw_held_ff;
  reg  [7:0]  aw_addr_ff;
  reg         w_held_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         refused_ff;

  wire        travel_direction_select = config_ff[`CFG_TRAVEL_DIR];
  wire        rate_unit_select        = config_ff[`CFG_RATE_UNIT];
  wire        linear_mode             = config_ff[`CFG_LINEAR_MODE];
  wire [1:0]  position_unit_select    = config_ff[`CFG_POS_UNIT_HI:`CFG_POS_UNIT_LO];

  // ========================================================================
  // AXI4-Lite write side: address and data held independently
  wire        wr_fire = (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid) && !s_axi_bvalid;
  wire [7:0]  wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire wr_tbl_pos = wr_fire && (wr_addr == `REG_TBL_POSITION);
  wire wr_tbl_spd = wr_fire && (wr_addr == `REG_TBL_SPEED);
  wire wr_tbl_dec = wr_fire && (wr_addr == `REG_TBL_DECEL);
  wire wr_tbl_dwl = wr_fire && (wr_addr == `REG_TBL_DWELL);
  wire wr_tbl_aux = wr_fire && (wr_addr == `REG_TBL_AUX);
  wire wr_ctrl    = wr_fire && (wr_addr == `REG_CTRL);

  // Position entries saturate on write in degree units, deceleration entries in time units
  reg [31:0] pos_in;
  reg [31:0] dec_in;
  always @* begin
    pos_in = wr_data;
    if (position_unit_select == `UNIT_DEGREE) begin
      if (!wr_data[31] && (wr_data > `DEG_LIMIT)) begin
        pos_in = `DEG_LIMIT;
      end else if (wr_data[31] && ((~wr_data + 32'h00000001) > `DEG_LIMIT)) begin
        pos_in = ~`DEG_LIMIT + 32'h00000001;
      end
    end
    dec_in = wr_data;
    if (!rate_unit_select && (wr_data > `DECEL_MS_MAX)) begin
      dec_in = `DECEL_MS_MAX;
    end
  end

  // ========================================================================
  // Table memories
  wire [31:0] rd_pos;
  wire [31:0] rd_spd;
  wire [31:0] rd_dec;
  wire [31:0] rd_aux;
  wire [31:0] rd_dwl;
  wire [7:0]  seq_addr = cur_table_ff;

  table_memory u_pos (.sys_clk_i(sys_clk_i), .wr_en_i(wr_tbl_pos), .wr_addr_i(tbl_index_ff),
    .wr_data_i(pos_in), .rd_addr_i(seq_addr), .rd_data_o(rd_pos));
  table_memory u_spd (.sys_clk_i(sys_clk_i), .wr_en_i(wr_tbl_spd), .wr_addr_i(tbl_index_ff),
    .wr_data_i(wr_data), .rd_addr_i(seq_addr), .rd_data_o(rd_spd));
  table_memory u_dec (.sys_clk_i(sys_clk_i), .wr_en_i(wr_tbl_dec), .wr_addr_i(tbl_index_ff),
    .wr_data_i(dec_in), .rd_addr_i(seq_addr), .rd_data_o(rd_dec));
  table_memory u_aux (.sys_clk_i(sys_clk_i), .wr_en_i(wr_tbl_aux), .wr_addr_i(tbl_index_ff),
    .wr_data_i(wr_data), .rd_addr_i(seq_addr), .rd_data_o(rd_aux));
  table_memory u_dwl (.sys_clk_i(sys_clk_i), .wr_en_i(wr_tbl_dwl), .wr_addr_i(tbl_index_ff),
    .wr_data_i((wr_data > `DWELL_MS_MAX) ? `DWELL_MS_MAX : wr_data), .rd_addr_i(seq_addr),
    .rd_data_o(rd_dwl));

  // ========================================================================
  // Register writes and write response
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      config_ff                  <= 32'h00000000;
      target_table_ff            <= `FIRST_TABLE;
      global_decel_time_param_ff <= `RST_GLOBAL_DECEL;
      max_speed_ff               <= `RST_MAX_SPEED;
      tbl_index_ff               <= 8'h00;
      aw_held_ff                 <= 1'b0;
      aw_addr_ff                 <= 8'h00;
      w_held_ff                  <= 1'b0;
      w_data_ff                  <= 32'h00000000;
      w_strb_ff                  <= 4'h0;
      s_axi_bvalid               <= 1'b0;
      s_axi_bresp                <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (wr_addr)
          `REG_CTRL:          ;
          `REG_CONFIG:        config_ff <= merge(config_ff, wr_data, wr_strb) & 32'h00000037;
          `REG_TARGET_TABLE:  target_table_ff <= wr_data[7:0];
          `REG_GLOBAL_DECEL:  global_decel_time_param_ff <= merge(global_decel_time_param_ff, wr_data, wr_strb);
          `REG_TBL_INDEX:     tbl_index_ff <= wr_data[7:0];
          `REG_MAX_SPEED:     max_speed_ff <= merge(max_speed_ff, wr_data, wr_strb);
          `REG_TBL_POSITION, `REG_TBL_SPEED, `REG_TBL_DECEL, `REG_TBL_DWELL, `REG_TBL_AUX: ;
          default:            s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  // ========================================================================
  // Sequencer
  wire        new_setpoint = wr_ctrl && wr_strb[0] && wr_data[`CTRL_NEW_SETPOINT];
  wire [3:0]  aux_code     = aux_ff[`AUX_CODE_HI:0];
  wire        is_relative  = aux_code[1];
  wire        ms_tick      = (ms_cnt_ff == MS_COUNT - 1);
  // Signed data with the direction setting applied
  wire [31:0] mapped_pos   = travel_direction_select ? (~pos_ff + 32'h00000001) : pos_ff;
  wire        next_neg     = mapped_pos[31];

  reg [7:0] successor;
  always @* begin
    case (aux_code)
      4'h8, 4'hA: successor = start_table_ff;
      4'h9, 4'hB: successor = `FIRST_TABLE;
      default:    successor = cur_table_ff + 8'h01;
    endcase
  end

  // Rate units: time in seconds is speed over deceleration
  wire [31:0] decel_time = (dec_ff == 32'h00000000) ? global_decel_time_param_ff : dec_ff;
  wire [31:0] speed_lim  = (spd_ff > max_speed_ff) ? max_speed_ff : spd_ff;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_ff            <= ST_IDLE;
      cur_table_ff        <= 8'h00;
      start_table_ff      <= 8'h00;
      ms_cnt_ff           <= 32'h00000000;
      dwell_cnt_ff        <= 32'h00000000;
      pos_ff              <= 32'h00000000;
      spd_ff              <= 32'h00000000;
      dec_ff              <= 32'h00000000;
      aux_ff              <= 32'h00000000;
      prev_neg_ff         <= 1'b0;
      have_prev_ff        <= 1'b0;
      active_code_ff      <= 16'h0000;
      refused_ff          <= 1'b0;
      cmd_start_o         <= 1'b0;
      cmd_position_o      <= 32'h00000000;
      cmd_relative_o      <= 1'b0;
      cmd_speed_o         <= 32'h00000000;
      cmd_decel_o         <= 32'h00000000;
      cmd_decel_is_rate_o <= 1'b0;
      cmd_speed_mm_o      <= 1'b0;
      busy_o              <= 1'b0;
      table_error_o       <= 1'b0;
    end else begin
      cmd_start_o <= 1'b0;
      // Restarts on dwell entry so a dwell lasts whole milliseconds
      ms_cnt_ff   <= (ms_tick || (state_ff != ST_DWELL)) ? 32'h00000000 : ms_cnt_ff + 32'h00000001;
      if (wr_ctrl && wr_strb[1] && wr_data[`CTRL_ERR_CLEAR]) begin
        table_error_o <= 1'b0;
        refused_ff    <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          busy_o       <= 1'b0;
          have_prev_ff <= 1'b0;
          // A start while the motor still turns is ignored
          if (new_setpoint && !motor_moving_i) begin
            cur_table_ff   <= target_table_ff;
            start_table_ff <= target_table_ff;
            busy_o         <= 1'b1;
            state_ff       <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_ff <= ST_CHECK;
        end
        ST_CHECK: begin
          pos_ff <= rd_pos;
          spd_ff <= rd_spd;
          dec_ff <= rd_dec;
          aux_ff <= rd_aux;
          dwell_cnt_ff <= rd_dwl;
          if (!aux_valid(rd_aux[`AUX_CODE_HI:0])) begin
            refused_ff <= 1'b1;
            state_ff   <= ST_IDLE;
          end else if ((cur_table_ff == `LAST_TABLE) && rd_aux[0] && !rd_aux[`AUX_CODE_HI]) begin
            table_error_o <= 1'b1;
            state_ff      <= ST_IDLE;
          end else begin
            state_ff <= ST_TURN;
          end
        end
        ST_TURN: begin
          // Opposite direction waits for the smoothed command to settle
          if (!have_prev_ff || (next_neg == prev_neg_ff) || smooth_zero_i) begin
            cmd_start_o         <= 1'b1;
            cmd_position_o      <= mapped_pos;
            cmd_relative_o      <= is_relative;
            cmd_speed_o         <= speed_lim;
            cmd_decel_o         <= decel_time;
            cmd_decel_is_rate_o <= rate_unit_select && (dec_ff != 32'h00000000);
            cmd_speed_mm_o      <= linear_mode;
            active_code_ff      <= {8'h00, aux_ff[`AUX_MCODE_HI:`AUX_MCODE_LO]};
            prev_neg_ff         <= next_neg;
            have_prev_ff        <= 1'b1;
            state_ff            <= ST_RUN;
          end
        end
        ST_RUN: begin
          // Done still shows the previous move while the start pulse is out
          if (!continues(aux_code)) begin
            if (motion_done_i && !cmd_start_o) begin
              state_ff <= ST_IDLE;
            end
          end else if (dwell_cnt_ff == 32'h00000000) begin
            cur_table_ff <= successor;
            state_ff     <= ST_FETCH;
          end else if (motion_done_i && !cmd_start_o) begin
            state_ff <= ST_DWELL;
          end
        end
        ST_DWELL: begin
          if (dwell_cnt_ff == 32'h00000000) begin
            cur_table_ff <= successor;
            state_ff     <= ST_FETCH;
          end else if (ms_tick) begin
            dwell_cnt_ff <= dwell_cnt_ff - 32'h00000001;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Read side
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `REG_CTRL:         s_axi_rdata <= 32'h00000000;
        `REG_CONFIG:       s_axi_rdata <= config_ff;
        `REG_TARGET_TABLE: s_axi_rdata <= {24'h000000, target_table_ff};
        `REG_GLOBAL_DECEL: s_axi_rdata <= global_decel_time_param_ff;
        `REG_TBL_INDEX:    s_axi_rdata <= {24'h000000, tbl_index_ff};
        `REG_STATUS:       s_axi_rdata <= {16'h0000, cur_table_ff, 3'h0, refused_ff, table_error_o, state_ff};
        `REG_ACTIVE_CODE:  s_axi_rdata <= {16'h0000, active_code_ff};
        `REG_CMD_POSITION: s_axi_rdata <= cmd_position_o;
        `REG_CMD_SPEED:    s_axi_rdata <= cmd_speed_o;
        `REG_CMD_DECEL:    s_axi_rdata <= cmd_decel_o;
        `REG_MAX_SPEED:    s_axi_rdata <= max_speed_ff;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end

endmodule

// ### bench/point_table_sequencer_asserts.sv
// Bus handshake and sequencing checks for the point table sequencer
`timescale 1ns/10ps
module point_table_sequencer_asserts (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  // Sequencer outputs
  input wire        cmd_start_o,
  input wire        busy_o,
  input wire        table_error_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Helpers
  // A clear may land one cycle after its write is taken
  logic clr_seen_ff;
  always @(posedge sys_clk_i) begin
    clr_seen_ff <= s_axi_wvalid & s_axi_wdata[8];
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================
  // Properties
  a_write_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered next cycle");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data changed while waiting");
  a_refuse_while_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during pending response");
  a_start_one_cycle: assert property (cmd_start_o |=> !cmd_start_o)
    else $error("start pulse longer than one cycle");
  a_start_when_busy: assert property (cmd_start_o |-> busy_o)
    else $error("start issued while idle");
  a_error_sticky: assert property (table_error_o && !s_axi_wvalid && !clr_seen_ff |=> table_error_o)
    else $error("table error dropped without clear");
endmodule
bind point_table_sequencer point_table_sequencer_asserts point_table_sequencer_asserts_i (.*);

// ### bench/motion_model.sv
// Behavioural motion generator answering the sequencer's start pulses
`timescale 1ns/10ps
module motion_model #(
  parameter int RUN = 12
) (
  // Clock and reset
  input  wire  sys_clk_i,
  input  wire  sys_rst_i,
  // Command
  input  wire  cmd_start_i,
  // Status
  output logic motion_done_o,
  output logic smooth_zero_o,
  output logic motor_moving_o
);
  int cnt_ff;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 0;
      motion_done_o <= 1'b0;
      smooth_zero_o <= 1'b1;
      motor_moving_o <= 1'b0;
    end else if (cmd_start_i) begin
      cnt_ff <= RUN;
      motion_done_o <= 1'b0;
      smooth_zero_o <= 1'b0;
      motor_moving_o <= 1'b1;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
      motion_done_o <= (cnt_ff == 1);
      motor_moving_o <= (cnt_ff != 1);
    end else begin
      // Smoothed output settles a cycle after the motor stops
      smooth_zero_o <= 1'b1;
    end
  end
endmodule

// ### bench/test_point_table_sequencer.sv
// Self-checking bench for the point table sequencer
`timescale 1ns/10ps
module test_point_table_sequencer;
  localparam int RUN = 12;
  localparam int MS = 4;
  logic sys_clk_i, sys_rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv, last_spd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rr;
  logic last_rel, last_rate, last_mm;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy_o, table_error_o;
  wire motion_done_i, smooth_zero_i, motor_moving_i, cmd_start_o, cmd_relative_o;
  wire cmd_decel_is_rate_o, cmd_speed_mm_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, cmd_position_o, cmd_speed_o, cmd_decel_o;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int at_q[$];
  logic [31:0] pos_q[$], dec_q[$];

  point_table_sequencer #(.MS_COUNT(MS)) point_table_sequencer_i (.*);
  motion_model #(.RUN(RUN)) motion_model_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cmd_start_i(cmd_start_o), .motion_done_o(motion_done_i), .smooth_zero_o(smooth_zero_i),
    .motor_moving_o(motor_moving_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Command monitor
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cmd_start_o === 1'b1) begin
      pos_q.push_back(cmd_position_o);
      dec_q.push_back(cmd_decel_o);
      at_q.push_back(cyc);
      last_spd = cmd_speed_o;
      last_rel = cmd_relative_o;
      last_rate = cmd_decel_is_rate_o;
      last_mm = cmd_speed_mm_o;
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awvalid & s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid & s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid & s_axi_bready) && n < 100);
    s_axi_bready <= 1'b0;
    chk({29'h0, n < 100, s_axi_bresp}, {29'h0, 1'b1, e});
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arvalid & s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid & s_axi_rready) && n < 100);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    chk({31'h0, n < 100}, 32'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    rd(a);
    chk(rv, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask
  task automatic tbl(input logic [7:0] i, input logic [31:0] p, s, d, w, x);
    wr(8'h10, {24'h0, i});
    wr(8'h14, p);
    wr(8'h18, s);
    wr(8'h1C, d);
    wr(8'h20, w);
    wr(8'h24, x);
  endtask
  task automatic run(input logic [7:0] t);
    int n;
    n = 0;
    pos_q.delete();
    dec_q.delete();
    at_q.delete();
    wr(8'h08, {24'h0, t});
    wr(8'h00, 32'h10);
    repeat (6) @(posedge sys_clk_i);
    while (busy_o !== 1'b0 && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk({31'h0, n < 2000}, 32'h1);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog, well beyond the several hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    num_errors++;
    give_verdict;
  end
  // ==========================================================
  // Tests
  initial begin
    sys_rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h1);
    rdc(8'h0C, 32'h0);
    rdc(8'h3C, 32'hEA60);
    rdc(8'h40, 32'h0, 2'h2);
    wr(8'h44, 32'h1, 2'h2);
    $display("test registers done");
    wr(8'h0C, 32'h64);
    tbl(8'h01, 32'h1F4, 32'h10000, 32'h0, 32'h5, 32'h500);
    run(8'h01);
    chk(pos_q.size(), 1);
    chk(pos_q[0], 32'h1F4);
    chk(last_spd, 32'hEA60);
    chk(dec_q[0], 32'h64);
    rdc(8'h2C, 32'h5);
    wr(8'h04, 32'h1);
    run(8'h01);
    chk(pos_q[0], 32'hFFFFFE0C);
    $display("test direction done");
    wr(8'h04, 32'h0);
    tbl(8'h02, 32'h64, 32'h3E8, 32'h7530, 32'h0, 32'h1);
    tbl(8'h03, 32'hC8, 32'h3E8, 32'hA, 32'h3, 32'h3);
    tbl(8'h04, 32'hFFFFFFCE, 32'h3E8, 32'hA, 32'h0, 32'h3);
    tbl(8'h05, 32'h12C, 32'h3E8, 32'hA, 32'h0, 32'h2);
    run(8'h02);
    chk(pos_q.size(), 4);
    chk({31'h0, last_rel}, 32'h1);
    chk(dec_q[0], 32'h4E20);
    chk({31'h0, at_q[1] - at_q[0] < RUN}, 32'h1);
    chk({31'h0, at_q[2] - at_q[1] >= RUN + 3 * MS}, 32'h1);
    chk({31'h0, at_q[3] - at_q[2] > RUN}, 32'h1);
    for (int c = 9; c <= 11; c += 2) begin
      tbl(8'h06, 32'h2BC, 32'h3E8, 32'hA, 32'h0, c);
      run(8'h06);
      chk(pos_q[1], 32'h1F4);
    end
    $display("test continuation done");
    wr(8'h04, 32'h26);
    tbl(8'h01, 32'h61A80, 32'h3E8, 32'hA, 32'h0, 32'h0);
    run(8'h01);
    chk(pos_q[0], 32'h57E40);
    chk({31'h0, last_rate}, 32'h1);
    chk({31'h0, last_mm}, 32'h1);
    wr(8'h04, 32'h30);
    tbl(8'h01, 32'h80000000, 32'h3E8, 32'hA, 32'h0, 32'h0);
    run(8'h01);
    chk(pos_q[0], 32'h80000000);
    chk({31'h0, last_rate}, 32'h0);
    $display("test units done");
    tbl(8'hFF, 32'h1, 32'h3E8, 32'hA, 32'h0, 32'h1);
    run(8'hFF);
    chk({31'h0, table_error_o}, 32'h1);
    wr(8'h00, 32'h100);
    chk({31'h0, table_error_o}, 32'h0);
    $display("test last table done");
    tbl(8'h07, 32'h1, 32'h3E8, 32'hA, 32'h0, 32'h5);
    run(8'h07);
    chk(pos_q.size(), 0);
    rd(8'h28);
    chk({31'h0, rv[4]}, 32'h1);
    $display("test invalid code done");
    give_verdict;
  end
endmodule
